// *** core/prescaler_div.sv ***
// Purpose: free-running tick prescaler producing counter update steps
// Assumes: tick_in is a one-cycle strobe from logic on clk_in
// Notes:   the divider count is never cleared by a ratio change
`timescale 1ns/1ps
`default_nettype none

module prescaler_div (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       tick_in,
  input  wire logic [1:0] div_sel_in,
  output logic            step_out
);

  logic [timer_pkg::PRE_W-1:0] pre_r;
  logic [timer_pkg::PRE_W-1:0] pre_nxt;
  logic [timer_pkg::PRE_W-1:0] mask;

  always_comb begin
    case (div_sel_in)
      timer_pkg::DIV_1:   mask = timer_pkg::MASK_1;
      timer_pkg::DIV_8:   mask = timer_pkg::MASK_8;
      timer_pkg::DIV_32:  mask = timer_pkg::MASK_32;
      timer_pkg::DIV_128: mask = timer_pkg::MASK_128;
      default:            mask = timer_pkg::MASK_1;
    endcase
    // a new ratio waits for the running count to line up
    step_out = tick_in && ((pre_r & mask) == mask);
    pre_nxt  = tick_in ? pre_r + timer_pkg::PRE_ONE : pre_r;
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      pre_r <= timer_pkg::PRE_RST;
    end else begin
      pre_r <= pre_nxt;
    end
  end

endmodule

`default_nettype wire

// *** core/timer_counter_control_status.sv ***
// Purpose: sixteen-bit timer core with prescaler, modes and flags
// Assumes: register port and event inputs share clk_in
// Notes:   the compare value is supplied by the channel 0 logic
//
// Functional notes
// - reading low byte returns it and snapshots the high byte
// - high byte register is read-only and returns the snapshot
// - any write to the low byte clears the whole counter
// - channel flags at bits 7,6,5; write zero clears, one keeps
// - overflow flag bit 4 on terminal count or turnaround at zero
// - prescaler field 3:2 divides tick by 1, 8, 32 or 128
// - prescaler count is not reset when the field is written
// - mode 00 suspends counting and holds the count
// - mode 01 counts 0 to ffff, wraps and repeats
// - mode 10 counts 0 to compare value, restarts from zero
// - up/down mode counts 0 up to compare value and back down
// - reset clears counter, flags, prescaler and mode fields
// - channel events set their pending flag regardless of mask
`timescale 1ns/1ps
`default_nettype none

module timer_counter_control_status (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // register port
  input  wire logic [7:0]  addr_in,
  input  wire logic [7:0]  wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [7:0]  rdata_out,
  // timing source and channel side
  input  wire logic        tick_in,
  input  wire logic [15:0] chan0_compare_value_in,
  input  wire logic [2:0]  chan_event_in,
  // observation
  output logic      [15:0] count_value_out,
  output logic      [3:0]  pending_flags_out
);

  ////////////////////////////////////////////////////////////////////////
  // state

  logic [15:0]     count_value_r;
  logic [15:0]     count_value_nxt;
  timer_pkg::dir_t dir_r;
  timer_pkg::dir_t dir_nxt;
  logic [7:0]      high_snap_r;
  logic [7:0]      high_snap_nxt;
  logic [7:0]      rdata_r;
  logic [7:0]      rdata_nxt;

  logic            chan2_pending_flag_r;
  logic            chan1_pending_flag_r;
  logic            chan0_pending_flag_r;
  logic            overflow_pending_flag_r;
  logic            chan2_pending_flag_nxt;
  logic            chan1_pending_flag_nxt;
  logic            chan0_pending_flag_nxt;
  logic            overflow_pending_flag_nxt;

  logic [1:0]      div_sel_r;
  logic [1:0]      div_sel_nxt;
  logic [1:0]      mode_r;
  logic [1:0]      mode_nxt;

  ////////////////////////////////////////////////////////////////////////
  // decode

  logic wr_lo;
  logic wr_ctl;
  logic rd_lo;
  logic rd_hi;
  logic rd_ctl;
  logic step;
  logic ovf_event;
  logic [7:0] ctl_view;

  always_comb begin
    wr_lo  = wr_in && (addr_in == timer_pkg::ADDR_CNT_LO);
    wr_ctl = wr_in && (addr_in == timer_pkg::ADDR_CTL);
    rd_lo  = rd_in && (addr_in == timer_pkg::ADDR_CNT_LO);
    rd_hi  = rd_in && (addr_in == timer_pkg::ADDR_CNT_HI);
    rd_ctl = rd_in && (addr_in == timer_pkg::ADDR_CTL);
  end

  ////////////////////////////////////////////////////////////////////////
  // prescaler

  prescaler_div u_prescaler (
    .clk_in     (clk_in),
    .rst_n_in   (rst_n_in),
    .tick_in    (tick_in),
    .div_sel_in (div_sel_r),
    .step_out   (step)
  );

  ////////////////////////////////////////////////////////////////////////
  // counter
  // a compare value lowered below the running count is caught by the
  // greater-or-equal test, so the counter never runs away to ffff

  always_comb begin
    count_value_nxt = count_value_r;
    dir_nxt         = dir_r;
    ovf_event       = 1'b0;
    if (step) begin
      case (mode_r)
        timer_pkg::MODE_SUSPEND: begin
          count_value_nxt = count_value_r;
        end
        timer_pkg::MODE_FREE: begin
          if (count_value_r == timer_pkg::CNT_MAX) begin
            count_value_nxt = timer_pkg::CNT_ZERO;
            ovf_event       = 1'b1;
          end else begin
            count_value_nxt = count_value_r + timer_pkg::CNT_ONE;
          end
        end
        timer_pkg::MODE_MODULO: begin
          if (count_value_r >= chan0_compare_value_in) begin
            count_value_nxt = timer_pkg::CNT_ZERO;
            ovf_event       = 1'b1;
          end else begin
            count_value_nxt = count_value_r + timer_pkg::CNT_ONE;
          end
        end
        timer_pkg::MODE_UPDOWN: begin
          case (dir_r)
            timer_pkg::DIR_UP: begin
              if (count_value_r >= chan0_compare_value_in) begin
                if (count_value_r != timer_pkg::CNT_ZERO) begin
                  count_value_nxt = count_value_r - timer_pkg::CNT_ONE;
                  dir_nxt         = timer_pkg::DIR_DOWN;
                end else begin
                  // compare value of zero: sit at zero counting up, flagging overflow each step
                  ovf_event = 1'b1;
                end
              end else begin
                count_value_nxt = count_value_r + timer_pkg::CNT_ONE;
              end
            end
            timer_pkg::DIR_DOWN: begin
              if (count_value_r == timer_pkg::CNT_ZERO) begin
                dir_nxt   = timer_pkg::DIR_UP;
                ovf_event = 1'b1;
                if (chan0_compare_value_in != timer_pkg::CNT_ZERO) begin
                  count_value_nxt = count_value_r + timer_pkg::CNT_ONE;
                end
              end else begin
                count_value_nxt = count_value_r - timer_pkg::CNT_ONE;
              end
            end
            default: begin
              dir_nxt = timer_pkg::DIR_UP;
            end
          endcase
        end
        default: begin
          count_value_nxt = count_value_r;
        end
      endcase
    end
    // software clear beats a step in the same cycle
    if (wr_lo) begin
      count_value_nxt = timer_pkg::CNT_ZERO;
      dir_nxt         = timer_pkg::DIR_UP;
    end
    // leaving up/down restarts the next up/down run counting up
    if (mode_r != timer_pkg::MODE_UPDOWN) begin
      dir_nxt = timer_pkg::DIR_UP;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      count_value_r <= timer_pkg::CNT_ZERO;
      dir_r         <= timer_pkg::DIR_UP;
    end else begin
      count_value_r <= count_value_nxt;
      dir_r         <= dir_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control fields and pending flags
  // writing one to a flag keeps it; a hardware set in the same cycle as
  // a clearing write wins, so no event is lost

  always_comb begin
    div_sel_nxt               = div_sel_r;
    mode_nxt                  = mode_r;
    chan2_pending_flag_nxt    = chan2_pending_flag_r;
    chan1_pending_flag_nxt    = chan1_pending_flag_r;
    chan0_pending_flag_nxt    = chan0_pending_flag_r;
    overflow_pending_flag_nxt = overflow_pending_flag_r;
    if (wr_ctl) begin
      div_sel_nxt = wdata_in[timer_pkg::DIV_HI:timer_pkg::DIV_LO];
      mode_nxt    = wdata_in[timer_pkg::MODE_HI:timer_pkg::MODE_LO];
      chan2_pending_flag_nxt =
        chan2_pending_flag_r & wdata_in[timer_pkg::CH2_BIT];
      chan1_pending_flag_nxt =
        chan1_pending_flag_r & wdata_in[timer_pkg::CH1_BIT];
      chan0_pending_flag_nxt =
        chan0_pending_flag_r & wdata_in[timer_pkg::CH0_BIT];
      overflow_pending_flag_nxt =
        overflow_pending_flag_r & wdata_in[timer_pkg::OVF_BIT];
    end
    if (chan_event_in[2]) begin
      chan2_pending_flag_nxt = 1'b1;
    end
    if (chan_event_in[1]) begin
      chan1_pending_flag_nxt = 1'b1;
    end
    if (chan_event_in[0]) begin
      chan0_pending_flag_nxt = 1'b1;
    end
    if (ovf_event) begin
      overflow_pending_flag_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      div_sel_r               <= timer_pkg::DIV_1;
      mode_r                  <= timer_pkg::MODE_SUSPEND;
      chan2_pending_flag_r    <= 1'b0;
      chan1_pending_flag_r    <= 1'b0;
      chan0_pending_flag_r    <= 1'b0;
      overflow_pending_flag_r <= 1'b0;
    end else begin
      div_sel_r               <= div_sel_nxt;
      mode_r                  <= mode_nxt;
      chan2_pending_flag_r    <= chan2_pending_flag_nxt;
      chan1_pending_flag_r    <= chan1_pending_flag_nxt;
      chan0_pending_flag_r    <= chan0_pending_flag_nxt;
      overflow_pending_flag_r <= overflow_pending_flag_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read path
  // the snapshot only moves on a low-byte read, so a high-byte read
  // pairs with the last low-byte read even if the counter moved since

  always_comb begin
    ctl_view                                         = timer_pkg::BYTE_RST;
    ctl_view[timer_pkg::CH2_BIT]                     = chan2_pending_flag_r;
    ctl_view[timer_pkg::CH1_BIT]                     = chan1_pending_flag_r;
    ctl_view[timer_pkg::CH0_BIT]                     = chan0_pending_flag_r;
    ctl_view[timer_pkg::OVF_BIT]                     = overflow_pending_flag_r;
    ctl_view[timer_pkg::DIV_HI:timer_pkg::DIV_LO]    = div_sel_r;
    ctl_view[timer_pkg::MODE_HI:timer_pkg::MODE_LO]  = mode_r;

    high_snap_nxt = high_snap_r;
    rdata_nxt     = timer_pkg::BYTE_RST;
    if (rd_lo) begin
      rdata_nxt     = count_value_r[7:0];
      high_snap_nxt = count_value_r[15:8];
    end else if (rd_hi) begin
      rdata_nxt = high_snap_r;
    end else if (rd_ctl) begin
      rdata_nxt = ctl_view;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      high_snap_r <= timer_pkg::BYTE_RST;
      rdata_r     <= timer_pkg::BYTE_RST;
    end else begin
      high_snap_r <= high_snap_nxt;
      rdata_r     <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs, all straight from flip-flops

  always_comb begin
    rdata_out            = rdata_r;
    count_value_out      = count_value_r;
    pending_flags_out[3] = chan2_pending_flag_r;
    pending_flags_out[2] = chan1_pending_flag_r;
    pending_flags_out[1] = chan0_pending_flag_r;
    pending_flags_out[0] = overflow_pending_flag_r;
  end

endmodule

`default_nettype wire

// *** core/timer_pkg.sv ***
// Purpose: shared constants for the sixteen-bit timer core
// Assumes: byte-wide register port, one clock domain
// Notes:   all offsets, field positions and codes live here
package timer_pkg;

  // register offsets
  localparam logic [7:0] ADDR_CNT_LO = 8'he2;
  localparam logic [7:0] ADDR_CNT_HI = 8'he3;
  localparam logic [7:0] ADDR_CTL    = 8'he4;

  // control/status field positions
  localparam int CH2_BIT  = 7;
  localparam int CH1_BIT  = 6;
  localparam int CH0_BIT  = 5;
  localparam int OVF_BIT  = 4;
  localparam int DIV_HI   = 3;
  localparam int DIV_LO   = 2;
  localparam int MODE_HI  = 1;
  localparam int MODE_LO  = 0;

  // mode field encodings
  localparam logic [1:0] MODE_SUSPEND = 2'h0;
  localparam logic [1:0] MODE_FREE    = 2'h1;
  localparam logic [1:0] MODE_MODULO  = 2'h2;
  localparam logic [1:0] MODE_UPDOWN  = 2'h3;

  // prescaler field encodings and the counter masks they select
  localparam logic [1:0] DIV_1   = 2'h0;
  localparam logic [1:0] DIV_8   = 2'h1;
  localparam logic [1:0] DIV_32  = 2'h2;
  localparam logic [1:0] DIV_128 = 2'h3;
  localparam int         PRE_W   = 7;
  localparam logic [PRE_W-1:0] MASK_1   = 7'h00;
  localparam logic [PRE_W-1:0] MASK_8   = 7'h07;
  localparam logic [PRE_W-1:0] MASK_32  = 7'h1f;
  localparam logic [PRE_W-1:0] MASK_128 = 7'h7f;
  localparam logic [PRE_W-1:0] PRE_RST  = 7'h00;
  localparam logic [PRE_W-1:0] PRE_ONE  = 7'h01;

  // counter values
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_MAX  = 16'hffff;
  localparam logic [15:0] CNT_ONE  = 16'h0001;

  // reset values
  localparam logic [7:0] BYTE_RST  = 8'h00;
  localparam logic [3:0] FLAGS_RST = 4'h0;

  // up/down direction state
  typedef enum logic {DIR_UP, DIR_DOWN} dir_t;

endpackage

// *** verification/tb_top.sv ***
// Purpose: directed bench for the timer core
// Assumes: tick held high apart from one gating check
// Notes:   the wrap scenario runs through a full 64k count
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic        clk_in;
  logic        rst_n_in;
  logic        wr_in;
  logic        rd_in;
  logic        tick_in;
  logic [7:0]  addr_in;
  logic [7:0]  wdata_in;
  logic [7:0]  rdata_out;
  logic [15:0] cmp;
  logic [15:0] cnt;
  logic [2:0]  ev;
  logic [3:0]  flags;
  logic [7:0]  d;
  logic [15:0] c;
  int          failures;
  int          checks_done;
  int          cycles;

  timer_counter_control_status dut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .tick_in(tick_in),
    .chan0_compare_value_in(cmp), .chan_event_in(ev),
    .count_value_out(cnt), .pending_flags_out(flags));

  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_in);
    wr_in <= 1'b1; addr_in <= a; wdata_in <= v;
    @(posedge clk_in);
    wr_in <= 1'b0;
    #1;
  endtask

  // read data stands only in the cycle after the strobe, so sample there
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk_in);
    rd_in <= 1'b1; addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask

  task automatic wait_count(input logic [15:0] v);
    for (int i = 0; i < 70000 && cnt !== v; i++) @(posedge clk_in) #1;
    // a wait that runs out must not pass silently
    if (cnt !== v) begin
      failures++;
      $display("unexpected at %0t: count %h awaited %h", $time, cnt, v);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd_reg(timer_pkg::ADDR_CNT_LO); chk(16'(d), 16'h0000);
    rd_reg(timer_pkg::ADDR_CNT_HI); chk(16'(d), 16'h0000);
    rd_reg(timer_pkg::ADDR_CTL); chk(16'(d), 16'h0000);
  endtask

  task automatic t_flags();
    @(posedge clk_in) ev <= 3'h7;
    @(posedge clk_in) ev <= 3'h0;
    rd_reg(timer_pkg::ADDR_CTL); chk(16'(d[7:5]), 16'h0007);
    wr_reg(timer_pkg::ADDR_CTL, 8'ha0);
    rd_reg(timer_pkg::ADDR_CTL); chk(16'(d[7:5]), 16'h0005);
    wr_reg(timer_pkg::ADDR_CTL, 8'h00);
    rd_reg(timer_pkg::ADDR_CTL); chk(16'(d), 16'h0000);
    // an event landing with a clearing write must survive it
    @(posedge clk_in);
    ev       <= 3'h4;
    wr_in    <= 1'b1;
    addr_in  <= timer_pkg::ADDR_CTL;
    wdata_in <= 8'h00;
    @(posedge clk_in);
    ev    <= 3'h0;
    wr_in <= 1'b0;
    rd_reg(timer_pkg::ADDR_CTL);
    chk(16'(d[7:5]), 16'h0004);
  endtask

  task automatic t_run_hold();
    wr_reg(timer_pkg::ADDR_CTL, 8'h01);
    c = cnt;
    repeat (5) @(posedge clk_in);
    #1 chk(cnt, c + 16'h0005);
    wr_reg(timer_pkg::ADDR_CTL, 8'h00);
    c = cnt;
    repeat (10) @(posedge clk_in);
    #1 chk(cnt, c);
  endtask

  // snapshot must survive the low byte rolling the high byte on
  task automatic t_latch();
    wr_reg(timer_pkg::ADDR_CTL, 8'h01);
    wait_count(16'h12fe);
    rd_reg(timer_pkg::ADDR_CNT_LO); chk(16'(d), 16'h00ff);
    rd_reg(timer_pkg::ADDR_CNT_HI); chk(16'(d), 16'h0012);
    wr_reg(timer_pkg::ADDR_CNT_HI, 8'h55);
    rd_reg(timer_pkg::ADDR_CNT_HI); chk(16'(d), 16'h0012);
    rd_reg(8'he7); chk(16'(d), 16'h0000);
    wr_reg(timer_pkg::ADDR_CNT_LO, 8'ha5); chk(cnt, 16'h0000);
  endtask

  task automatic t_wrap();
    wait_count(16'hffff);
    @(posedge clk_in);
    #1 chk(cnt, 16'h0000);
    chk(16'(flags[0]), 16'h0001);
  endtask

  task automatic t_div();
    int sh[4] = '{0, 3, 5, 7};
    for (int k = 0; k < 4; k++) begin
      wr_reg(timer_pkg::ADDR_CTL, {4'h0, 2'(k), 2'h1});
      repeat (128) @(posedge clk_in);
      #1 c = cnt;
      repeat (256) @(posedge clk_in);
      #1 chk(cnt - c, 16'(256 >> sh[k]));
    end
  endtask

  // right after a /128 step the divider sits at zero; switching to /8
  // must give the next step on the eighth edge, not eight after the write
  task automatic t_pre_keep();
    logic [15:0] c0;
    c0 = cnt;
    wait_count(c0 + 16'h0001);
    wr_reg(timer_pkg::ADDR_CTL, 8'h05);
    c = cnt;
    repeat (5) @(posedge clk_in);
    #1 chk(cnt, c);
    @(posedge clk_in);
    #1 chk(cnt, c + 16'h0001);
    wr_reg(timer_pkg::ADDR_CTL, 8'h01);
    @(posedge clk_in);
    tick_in <= 1'b0;
    #1 c = cnt;
    repeat (10) @(posedge clk_in);
    #1 chk(cnt, c);
    tick_in <= 1'b1;
  endtask

  task automatic t_modulo();
    logic [15:0] mx;
    mx = 16'h0000;
    cmp <= 16'h0005;
    wr_reg(timer_pkg::ADDR_CTL, 8'h02);
    wr_reg(timer_pkg::ADDR_CNT_LO, 8'h00);
    repeat (20) @(posedge clk_in) #1 if (cnt > mx) mx = cnt;
    chk(mx, 16'h0005);
    chk(16'(flags[0]), 16'h0001);
  endtask

  task automatic t_updown();
    logic [15:0] seq[8] = '{16'h0001, 16'h0002, 16'h0003, 16'h0002,
                            16'h0001, 16'h0000, 16'h0001, 16'h0002};
    cmp <= 16'h0003;
    wr_reg(timer_pkg::ADDR_CTL, 8'h00);
    wr_reg(timer_pkg::ADDR_CNT_LO, 8'h00);
    wr_reg(timer_pkg::ADDR_CTL, 8'h03);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_in);
      #1 chk(cnt, seq[i]);
    end
    chk(16'(flags[0]), 16'h0001);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // ceiling covers the 64k wrap plus every other scenario with margin
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 100000) begin
      failures++;
      report_and_stop();
    end
  end

  initial begin
    rst_n_in = 1'b0; wr_in = 1'b0; rd_in = 1'b0; tick_in = 1'b1;
    addr_in = 8'h00; wdata_in = 8'h00; cmp = 16'hffff; ev = 3'h0;
    failures = 0; checks_done = 0; cycles = 0;
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_reset();
    t_flags();
    t_run_hold();
    t_latch();
    t_wrap();
    t_div();
    t_pre_keep();
    t_modulo();
    t_updown();
    report_and_stop();
  end
endmodule
`default_nettype wire

// *** verification/timer_props.sv ***
// Purpose: concurrent checks on the timer core ports
// Assumes: one clock, synchronous active-low reset
// Notes:   the mode field is shadowed from control writes
`timescale 1ns/1ps
`default_nettype none

module timer_props (
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  input wire logic [7:0]  addr_in,
  input wire logic [7:0]  wdata_in,
  input wire logic        wr_in,
  input wire logic        rd_in,
  input wire logic [7:0]  rdata_out,
  input wire logic        tick_in,
  input wire logic [15:0] chan0_compare_value_in,
  input wire logic [2:0]  chan_event_in,
  input wire logic [15:0] count_value_out,
  input wire logic [3:0]  pending_flags_out
);
  logic [1:0] mode_r;
  logic [1:0] mode_nxt;
  logic [7:0] snap_r;
  logic [7:0] snap_nxt;
  logic       wr_lo;
  logic       wr_ctl;
  logic       rd_lo;
  logic       rd_hi;
  assign wr_lo  = wr_in && addr_in == timer_pkg::ADDR_CNT_LO;
  assign wr_ctl = wr_in && addr_in == timer_pkg::ADDR_CTL;
  assign rd_lo  = rd_in && addr_in == timer_pkg::ADDR_CNT_LO;
  assign rd_hi  = rd_in && addr_in == timer_pkg::ADDR_CNT_HI;

  always_comb begin
    mode_nxt = mode_r;
    snap_nxt = snap_r;
    if (wr_ctl)
      mode_nxt = wdata_in[1:0];
    if (rd_lo)
      snap_nxt = count_value_out[15:8];
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      mode_r <= 2'h0;
      snap_r <= 8'h00;
    end else begin
      mode_r <= mode_nxt;
      snap_r <= snap_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  a_low_read: assert property (rd_lo
    |=> rdata_out == $past(count_value_out[7:0])) else $error("low read bad");
  a_high_snap: assert property (rd_hi
    |=> rdata_out == snap_r) else $error("high read not snapshot");
  a_low_clear: assert property (wr_lo
    |=> count_value_out == timer_pkg::CNT_ZERO) else $error("no clear");
  a_flag_set: assert property (|chan_event_in |=>
    (pending_flags_out[3:1] & $past(chan_event_in)) == $past(chan_event_in))
    else $error("event flag not set");
  a_flag_sticky: assert property (!wr_ctl
    |=> (pending_flags_out & $past(pending_flags_out))
        == $past(pending_flags_out)) else $error("flag lost");
  a_suspend_hold: assert property (!wr_lo
    && mode_r == timer_pkg::MODE_SUSPEND |=> $stable(count_value_out))
    else $error("count moved");
  a_free_wrap: assert property (mode_r == timer_pkg::MODE_FREE
    && count_value_out == timer_pkg::CNT_MAX && !wr_lo
    |=> count_value_out == timer_pkg::CNT_MAX
        || (count_value_out == timer_pkg::CNT_ZERO && pending_flags_out[0]))
    else $error("bad wrap");
  a_mod_top: assert property (mode_r == timer_pkg::MODE_MODULO
    && count_value_out >= chan0_compare_value_in && !wr_lo
    |=> $stable(count_value_out)
        || (count_value_out == timer_pkg::CNT_ZERO && pending_flags_out[0]))
    else $error("bad modulo restart");
  a_reset_clear: assert property (disable iff (1'b0) !rst_n_in
    |=> count_value_out == 16'h0000 && pending_flags_out == 4'h0)
    else $error("reset not cleared");
endmodule

bind timer_counter_control_status timer_props u_props (
  .clk_in                 (clk_in),
  .rst_n_in               (rst_n_in),
  .addr_in                (addr_in),
  .wdata_in               (wdata_in),
  .wr_in                  (wr_in),
  .rd_in                  (rd_in),
  .rdata_out              (rdata_out),
  .tick_in                (tick_in),
  .chan0_compare_value_in (chan0_compare_value_in),
  .chan_event_in          (chan_event_in),
  .count_value_out        (count_value_out),
  .pending_flags_out      (pending_flags_out)
);
`default_nettype wire
